// File: frr_chk.sv
// Concurrent checks of fault routing at the top module ports.
`timescale 1ns/1ps
module frr_chk
  import frr_pkg::*;
(
  // Clock, reset and registers
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_mask_wr,
  input wire logic [FRR_REG_W-1:0] i_mask_wdata,
  input wire logic [FRR_REG_W-1:0] o_mask_rdata,
  input wire logic [FRR_REG_W-1:0] o_fs_rdata,
  // Faults
  input wire logic i_overcurrent,
  input wire logic i_gate_monitor,
  input wire logic i_vcc2_undervoltage,
  input wire logic i_switch_thermal,
  input wire logic i_die_thermal,
  input wire logic i_trim_checksum,
  input wire logic i_selftest_fault,
  // Outputs
  input wire logic o_fault_alarm_out_n,
  input wire logic o_warning_out_n,
  input wire logic o_secondary_shutdown,
  input wire logic o_gate_pull_low,
  input wire logic [FRR_REG_W-1:0] o_reported_faults
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic [15:0] mk = o_mask_rdata;
  property p_oc; i_overcurrent && !mk[13] |=> !o_fault_alarm_out_n; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent missing on alarm");
  property p_gm; i_gate_monitor && mk[12:11] == FRR_GM_WARN |=> !o_warning_out_n; endproperty
  a_gm: assert property (p_gm) else $error("gate monitor missing on warning");
  property p_uv; i_vcc2_undervoltage && !mk[10] |=> !o_fault_alarm_out_n; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage missing on alarm");
  property p_sw; i_switch_thermal && mk[8] |=> !o_fault_alarm_out_n; endproperty
  a_sw: assert property (p_sw) else $error("switch thermal missing on alarm");
  property p_sd; 1 |=> o_secondary_shutdown == $past(i_die_thermal); endproperty
  a_sd: assert property (p_sd) else $error("shutdown does not follow die thermal");
  property p_trim; i_trim_checksum && !mk[4] |=> !o_fault_alarm_out_n ##0 !o_warning_out_n;
  endproperty
  a_trim: assert property (p_trim) else $error("trim fault missing on a pin");
  property p_st; i_selftest_fault && !mk[2] |=> !(o_fault_alarm_out_n || o_warning_out_n);
  endproperty
  a_st: assert property (p_st) else $error("self-test fault missing on a pin");
  property p_quiet; (o_reported_faults & 16'h6FFF) == 16'h0 |-> o_fault_alarm_out_n; endproperty
  a_quiet: assert property (p_quiet) else $error("alarm low with nothing reported");
  property p_wr; i_mask_wr |=> o_mask_rdata == $past(i_mask_wdata); endproperty
  a_wr: assert property (p_wr) else $error("mask write not stored");
  property p_ocfs;
    i_overcurrent && !mk[13] && o_fs_rdata[9:8] == FRR_FS_PULL_LOW |=> o_gate_pull_low;
  endproperty
  a_ocfs: assert property (p_ocfs) else $error("overcurrent did not pull gate low");
  c_alarm: cover property (!o_fault_alarm_out_n);
  c_warn: cover property (!o_warning_out_n);
  c_sd: cover property (o_secondary_shutdown);
  c_gate: cover property (o_gate_pull_low);
endmodule
bind frr_top frr_chk u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_mask_wr(i_mask_wr), .i_mask_wdata(i_mask_wdata), .o_mask_rdata(o_mask_rdata),
  .o_fs_rdata(o_fs_rdata), .i_overcurrent(i_overcurrent), .i_gate_monitor(i_gate_monitor),
  .i_vcc2_undervoltage(i_vcc2_undervoltage), .i_switch_thermal(i_switch_thermal),
  .i_die_thermal(i_die_thermal), .i_trim_checksum(i_trim_checksum),
  .i_selftest_fault(i_selftest_fault), .o_fault_alarm_out_n(o_fault_alarm_out_n),
  .o_warning_out_n(o_warning_out_n), .o_secondary_shutdown(o_secondary_shutdown),
  .o_gate_pull_low(o_gate_pull_low), .o_reported_faults(o_reported_faults));

// File: frr_fs_decode.sv
// Decoder from one two-bit fail-safe field and its fault to a gate action.
`timescale 1ns/1ps
module frr_fs_decode
  import frr_pkg::*;
#(
  parameter bit HIZ_AT_TWO = 1'b0
) (
  // Fault and field
  input wire logic i_fault,
  input wire logic [1:0] i_state,
  // Requested gate action
  output logic o_pull_low,
  output logic o_pull_high,
  output logic o_hiz
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Code two is reserved on most fields and is then treated as no action.
  always_comb begin
    o_pull_low = 1'b0;
    o_pull_high = 1'b0;
    o_hiz = 1'b0;
    if (i_fault) begin
      case (i_state)
        FRR_FS_PULL_LOW: o_pull_low = 1'b1;
        FRR_FS_PULL_HIGH: o_pull_high = 1'b1;
        FRR_FS_CODE_TWO: o_hiz = HIZ_AT_TWO;
        default: o_hiz = 1'b0;
      endcase
    end
  end

endmodule

// File: frr_host_model.sv
// Host model that samples the alarm and warning pins every cycle.
`timescale 1ns/1ps
module frr_host_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Pins from the driver
  input wire logic i_fault_alarm_out_n,
  input wire logic i_warning_out_n,
  // Sampled state
  output logic o_alarm_seen,
  output logic o_warning_seen
);
  // The host only reads the pins, so it never loads or drives them.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alarm_seen <= 1'h0;
      o_warning_seen <= 1'h0;
    end else begin
      o_alarm_seen <= ~i_fault_alarm_out_n;
      o_warning_seen <= ~i_warning_out_n;
    end
  end
endmodule

// File: frr_pkg.sv
// Constants for fault report routing: field positions, reset values and encodings.
package frr_pkg;

  // ---------------------------------------------------------------
  // Register geometry
  // ---------------------------------------------------------------
  localparam int FRR_REG_W = 16;

  // ---------------------------------------------------------------
  // Fault report mask register fields
  // ---------------------------------------------------------------
  localparam int FRR_SPARE_BIT = 15;
  localparam int FRR_SC_BIT = 14;
  localparam int FRR_OC_BIT = 13;
  localparam int FRR_GM_HI = 12;
  localparam int FRR_GM_LO = 11;
  localparam int FRR_UV_BIT = 10;
  localparam int FRR_OV_BIT = 9;
  localparam int FRR_SW_THERM_BIT = 8;
  localparam int FRR_DIE_THERM_BIT = 7;
  localparam int FRR_LINK_BIT = 6;
  localparam int FRR_CFG_CRC_BIT = 5;
  localparam int FRR_TRIM_CRC_BIT = 4;
  localparam int FRR_REG_FLT_BIT = 3;
  localparam int FRR_SELFTEST_BIT = 2;
  localparam int FRR_ILIM_BIT = 1;
  localparam int FRR_CLK_BIT = 0;
  localparam logic [15:0] FRR_MASK_RESET = 16'h8940;

  // ---------------------------------------------------------------
  // Gate monitor route encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FRR_GM_MASKED = 2'h0;
  localparam logic [1:0] FRR_GM_ALARM = 2'h1;
  localparam logic [1:0] FRR_GM_WARN = 2'h2;
  localparam logic [1:0] FRR_GM_LIVE = 2'h3;

  // ---------------------------------------------------------------
  // Fail-safe output state register fields
  // ---------------------------------------------------------------
  localparam int FRR_TWN_EN_BIT = 15;
  localparam int FRR_FS_REGF_BIT = 11;
  localparam int FRR_FS_NUM = 5;
  // Field low bits: short circuit, over-current, switch thermal, gate monitor, link.
  localparam int FRR_FS_LSB [FRR_FS_NUM] = '{12, 8, 6, 2, 0};
  localparam int FRR_FS_GM_IDX = 3;
  localparam logic [15:0] FRR_FS_RESET = 16'hC008;

  // ---------------------------------------------------------------
  // Fail-safe action encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FRR_FS_PULL_LOW = 2'h0;
  localparam logic [1:0] FRR_FS_PULL_HIGH = 2'h1;
  localparam logic [1:0] FRR_FS_CODE_TWO = 2'h2;
  localparam logic [1:0] FRR_FS_NO_ACTION = 2'h3;

endpackage

// File: frr_top.sv
// Secondary-side fault report routing with fail-safe gate state selection.
// Notes on behaviour
// - Over-current fault drives alarm when its mask bit is zero.
// - Gate monitor field: masked, alarm, warning, or live gate state on warning.
// - Secondary under-voltage faults drive alarm unless masked.
// - Secondary over-voltage faults drive alarm unless masked.
// - Switch thermal shutdown reaches alarm only when its enable bit is one.
// - Die thermal shutdown drives alarm unless masked.
// - Die thermal shutdown always shuts the secondary side down.
// - Link fault reaches alarm only when its enable bit is one.
// - Configuration checksum fault drives alarm unless masked.
// - Trim checksum fault drives both fault outputs unless masked.
// - Internal regulator fault drives alarm unless masked.
// - Self-test failure drives alarm and warning unless masked.
// - Regulator current-limit fault drives alarm unless masked.
// - Clock monitor fault drives alarm unless masked.
// - Short-circuit fault drives alarm unless masked.
// - Fail-safe fields: low, high, reserved, no action on their fault.
// - Gate monitor fail-safe code two puts gates in high impedance.
`timescale 1ns/1ps
module frr_top
  import frr_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Register access
  input wire logic i_mask_wr,
  input wire logic [FRR_REG_W-1:0] i_mask_wdata,
  input wire logic i_fs_wr,
  input wire logic [FRR_REG_W-1:0] i_fs_wdata,
  output logic [FRR_REG_W-1:0] o_mask_rdata,
  output logic [FRR_REG_W-1:0] o_fs_rdata,
  // Fault detector levels
  input wire logic i_short_circuit,
  input wire logic i_overcurrent,
  input wire logic i_gate_monitor,
  input wire logic i_gate_voltage_state,
  input wire logic i_vcc2_undervoltage,
  input wire logic i_vee2_undervoltage,
  input wire logic i_vcc2_overvoltage,
  input wire logic i_vee2_overvoltage,
  input wire logic i_switch_thermal,
  input wire logic i_die_thermal,
  input wire logic i_die_temp_warning,
  input wire logic i_link_fault,
  input wire logic i_config_checksum,
  input wire logic i_trim_checksum,
  input wire logic i_regulator_fault,
  input wire logic i_selftest_fault,
  input wire logic i_regulator_current_limit,
  input wire logic i_clock_watch,
  // Host-facing fault outputs
  output logic o_fault_alarm_out_n,
  output logic o_warning_out_n,
  // Secondary side and gate control
  output logic o_secondary_shutdown,
  output logic o_gate_pull_low,
  output logic o_gate_pull_high,
  output logic o_gate_hiz,
  // Status
  output logic [FRR_REG_W-1:0] o_reported_faults
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [FRR_REG_W-1:0] mask_reg;
  logic [FRR_REG_W-1:0] fs_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask_reg <= FRR_MASK_RESET;
    end else if (i_mask_wr) begin
      mask_reg <= i_mask_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fs_reg <= FRR_FS_RESET;
    end else if (i_fs_wr) begin
      fs_reg <= i_fs_wdata;
    end
  end

  assign o_mask_rdata = mask_reg;
  assign o_fs_rdata = fs_reg;

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  logic short_circuit_report_mask;
  logic overcurrent_report_mask;
  logic [1:0] gate_monitor_report_route;
  logic secondary_undervoltage_report_mask;
  logic secondary_overvoltage_report_mask;
  logic switch_thermal_report_enable;
  logic die_thermal_report_mask;
  logic link_fault_report_enable;
  logic config_checksum_report_mask;
  logic trim_checksum_report_mask;
  logic regulator_fault_report_mask;
  logic selftest_fault_report_mask;
  logic regulator_current_limit_report_mask;
  logic clock_watch_report_mask;
  logic die_temp_warning_enable;

  assign short_circuit_report_mask = mask_reg[FRR_SC_BIT];
  assign overcurrent_report_mask = mask_reg[FRR_OC_BIT];
  assign gate_monitor_report_route = mask_reg[FRR_GM_HI:FRR_GM_LO];
  assign secondary_undervoltage_report_mask = mask_reg[FRR_UV_BIT];
  assign secondary_overvoltage_report_mask = mask_reg[FRR_OV_BIT];
  assign switch_thermal_report_enable = mask_reg[FRR_SW_THERM_BIT];
  assign die_thermal_report_mask = mask_reg[FRR_DIE_THERM_BIT];
  assign link_fault_report_enable = mask_reg[FRR_LINK_BIT];
  assign config_checksum_report_mask = mask_reg[FRR_CFG_CRC_BIT];
  assign trim_checksum_report_mask = mask_reg[FRR_TRIM_CRC_BIT];
  assign regulator_fault_report_mask = mask_reg[FRR_REG_FLT_BIT];
  assign selftest_fault_report_mask = mask_reg[FRR_SELFTEST_BIT];
  assign regulator_current_limit_report_mask = mask_reg[FRR_ILIM_BIT];
  assign clock_watch_report_mask = mask_reg[FRR_CLK_BIT];
  assign die_temp_warning_enable = fs_reg[FRR_TWN_EN_BIT];

  // ---------------------------------------------------------------
  // Per-source report terms
  // ---------------------------------------------------------------
  logic rep_sc;
  logic rep_oc;
  logic rep_gm_alarm;
  logic rep_gm_warn;
  logic rep_uv;
  logic rep_ov;
  logic rep_sw_thermal;
  logic rep_die_thermal;
  logic rep_link;
  logic rep_cfg_crc;
  logic rep_trim_crc;
  logic rep_reg_flt;
  logic rep_selftest;
  logic rep_ilim;
  logic rep_clk;
  logic rep_twn;

  assign rep_sc = i_short_circuit && !short_circuit_report_mask;
  assign rep_oc = i_overcurrent && !overcurrent_report_mask;
  assign rep_uv = (i_vcc2_undervoltage || i_vee2_undervoltage)
                  && !secondary_undervoltage_report_mask;
  assign rep_ov = (i_vcc2_overvoltage || i_vee2_overvoltage)
                  && !secondary_overvoltage_report_mask;
  assign rep_sw_thermal = i_switch_thermal && switch_thermal_report_enable;
  assign rep_die_thermal = i_die_thermal && !die_thermal_report_mask;
  assign rep_link = i_link_fault && link_fault_report_enable;
  assign rep_cfg_crc = i_config_checksum && !config_checksum_report_mask;
  assign rep_trim_crc = i_trim_checksum && !trim_checksum_report_mask;
  assign rep_reg_flt = i_regulator_fault && !regulator_fault_report_mask;
  assign rep_selftest = i_selftest_fault && !selftest_fault_report_mask;
  assign rep_ilim = i_regulator_current_limit
                    && !regulator_current_limit_report_mask;
  assign rep_clk = i_clock_watch && !clock_watch_report_mask;
  assign rep_twn = i_die_temp_warning && die_temp_warning_enable;

  // In live mode the warning pin follows the gate voltage, not the fault,
  // so the host sees switching activity rather than a latched condition.
  always_comb begin
    rep_gm_alarm = 1'b0;
    rep_gm_warn = 1'b0;
    case (gate_monitor_report_route)
      FRR_GM_MASKED: rep_gm_warn = 1'b0;
      FRR_GM_ALARM: rep_gm_alarm = i_gate_monitor;
      FRR_GM_WARN: rep_gm_warn = i_gate_monitor;
      FRR_GM_LIVE: rep_gm_warn = i_gate_voltage_state;
      default: rep_gm_warn = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Output combining
  // ---------------------------------------------------------------
  logic alarm_any;
  logic warn_any;
  logic [FRR_REG_W-1:0] reported_next;

  assign alarm_any = rep_sc || rep_oc || rep_gm_alarm || rep_uv || rep_ov
                     || rep_sw_thermal || rep_die_thermal || rep_link || rep_cfg_crc
                     || rep_trim_crc || rep_reg_flt || rep_selftest || rep_ilim
                     || rep_clk;
  assign warn_any = rep_gm_warn || rep_trim_crc || rep_selftest || rep_twn;

  assign reported_next = {rep_twn, rep_sc, rep_oc, rep_gm_warn, rep_gm_alarm,
                          rep_uv, rep_ov, rep_sw_thermal, rep_die_thermal, rep_link,
                          rep_cfg_crc, rep_trim_crc, rep_reg_flt, rep_selftest,
                          rep_ilim, rep_clk};

  // Pins are registered so that glitches between detectors never reach the host.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fault_alarm_out_n <= 1'b1;
      o_warning_out_n <= 1'b1;
    end else begin
      o_fault_alarm_out_n <= !alarm_any;
      o_warning_out_n <= !warn_any;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reported_faults <= '0;
    end else begin
      o_reported_faults <= reported_next;
    end
  end

  // ---------------------------------------------------------------
  // Secondary shutdown
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_secondary_shutdown <= 1'b0;
    end else begin
      o_secondary_shutdown <= i_die_thermal;
    end
  end

  // ---------------------------------------------------------------
  // Fail-safe gate state
  // ---------------------------------------------------------------
  logic [FRR_FS_NUM-1:0] fs_fault;
  logic [FRR_FS_NUM-1:0] fs_low;
  logic [FRR_FS_NUM-1:0] fs_high;
  logic [FRR_FS_NUM-1:0] fs_hiz;
  logic regf_low;

  assign fs_fault = {i_link_fault, i_gate_monitor, i_switch_thermal,
                     i_overcurrent, i_short_circuit};

  generate
    for (genvar g = 0; g < FRR_FS_NUM; g++) begin : g_fs
      frr_fs_decode #(
        .HIZ_AT_TWO(g == FRR_FS_GM_IDX)
      ) u_dec (
        .i_fault(fs_fault[g]),
        .i_state(fs_reg[FRR_FS_LSB[g] +: 2]),
        .o_pull_low(fs_low[g]),
        .o_pull_high(fs_high[g]),
        .o_hiz(fs_hiz[g])
      );
    end
  endgenerate

  // The regulator field is one bit wide: zero pulls low, one does nothing.
  assign regf_low = i_regulator_fault && !fs_reg[FRR_FS_REGF_BIT];

  // Pull low wins over high, and both over high impedance, to favour a safe off.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gate_pull_low <= 1'b0;
      o_gate_pull_high <= 1'b0;
      o_gate_hiz <= 1'b0;
    end else begin
      o_gate_pull_low <= (|fs_low) || regf_low;
      o_gate_pull_high <= (|fs_high) && !((|fs_low) || regf_low);
      o_gate_hiz <= (|fs_hiz) && !(|fs_high) && !((|fs_low) || regf_low);
    end
  end

endmodule

// File: tb_top.sv
// Self-checking bench for fault report routing.
`timescale 1ns/1ps
module tb_top;
  import frr_pkg::*;
  typedef struct {int due; logic [15:0] rm, rf, rep; logic al, wn, sd; logic [2:0] g; bit gc;}
    frr_note_t;
  logic i_core_clk = 1'h0;
  logic i_arst_n = 1'h0;
  logic mwr = 1'h0, fwr = 1'h0;
  logic [15:0] mwd = 16'h0, fwd = 16'h0;
  logic [17:0] f = 18'h0;
  wire logic [15:0] mrd, frd, rep;
  wire logic al_n, wn_n, sd, gl, gh, gz, h_al, h_wn;
  frr_note_t q[$];
  int cyc = 0, err_total = 0, num_checks = 0;
  frr_top DUT (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_mask_wr(mwr),
    .i_mask_wdata(mwd), .i_fs_wr(fwr), .i_fs_wdata(fwd), .o_mask_rdata(mrd), .o_fs_rdata(frd),
    .i_clock_watch(f[0]), .i_regulator_current_limit(f[1]), .i_selftest_fault(f[2]),
    .i_regulator_fault(f[3]), .i_trim_checksum(f[4]), .i_config_checksum(f[5]),
    .i_link_fault(f[6]), .i_die_thermal(f[7]), .i_switch_thermal(f[8]),
    .i_vcc2_overvoltage(f[9]), .i_vcc2_undervoltage(f[10]), .i_gate_monitor(f[11]),
    .i_gate_voltage_state(f[12]), .i_overcurrent(f[13]), .i_short_circuit(f[14]),
    .i_die_temp_warning(f[15]), .i_vee2_undervoltage(f[16]), .i_vee2_overvoltage(f[17]),
    .o_fault_alarm_out_n(al_n), .o_warning_out_n(wn_n), .o_secondary_shutdown(sd),
    .o_gate_pull_low(gl), .o_gate_pull_high(gh), .o_gate_hiz(gz), .o_reported_faults(rep));
  frr_host_model u_host (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_fault_alarm_out_n(al_n), .i_warning_out_n(wn_n), .o_alarm_seen(h_al),
    .o_warning_seen(h_wn));
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) cyc <= cyc + 1;
  task automatic bad(string s);
    err_total++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic frr_note_t exp_note(logic [15:0] m, fs, logic [17:0] v);
    frr_note_t n;
    logic [15:0] r;
    logic [1:0] c;
    logic lo, hi, hz;
    int src [FRR_FS_NUM] = '{14, 13, 8, 11, 6};
    r = v[15:0] & ~m;
    r[6] = v[6] & m[6];
    r[8] = v[8] & m[8];
    r[9] = (v[9] | v[17]) & ~m[9];
    r[10] = (v[10] | v[16]) & ~m[10];
    r[11] = v[11] && m[12:11] == FRR_GM_ALARM;
    r[12] = (v[11] && m[12:11] == FRR_GM_WARN) || (v[12] && m[12:11] == FRR_GM_LIVE);
    r[15] = v[15] & fs[15];
    n.rep = r;
    n.al = ~|(r & 16'h6FFF);
    n.wn = ~(r[12] | r[4] | r[2] | r[15]);
    n.sd = v[7];
    lo = v[3] && !fs[11];
    hi = 1'h0;
    hz = 1'h0;
    for (int k = 0; k < FRR_FS_NUM; k++) begin
      c = fs[FRR_FS_LSB[k] +: 2];
      lo |= v[src[k]] && c == FRR_FS_PULL_LOW;
      hi |= v[src[k]] && c == FRR_FS_PULL_HIGH;
      hz |= v[src[k]] && c == FRR_FS_CODE_TWO && k == FRR_FS_GM_IDX;
    end
    n.g = {lo, hi && !lo, hz && !hi && !lo};
    n.rm = m;
    n.rf = fs;
    n.gc = 1'b0;
    n.due = cyc;
    return n;
  endfunction
  // Each step writes both registers, then applies faults; the pins answer one edge later.
  task automatic step(logic [15:0] m, fs, logic [17:0] v, bit gc);
    frr_note_t n;
    @(posedge i_core_clk) #1;
    {mwr, fwr, mwd, fwd} = {2'h3, m, fs};
    @(posedge i_core_clk) #1;
    {mwr, fwr, f} = {2'h0, v};
    @(posedge i_core_clk) #1;
    n = exp_note(m, fs, v);
    n.gc = gc;
    q.push_back(n);
  endtask
  task automatic do_reset();
    @(posedge i_core_clk) #1;
    i_arst_n = 1'h0;
    repeat (3) @(posedge i_core_clk);
    #1;
    q.push_back(exp_note(FRR_MASK_RESET, FRR_FS_RESET, 18'h0));
    if ({h_al, h_wn} !== 2'h0) bad("host saw a fault in reset");
    @(posedge i_core_clk) #1;
    i_arst_n = 1'h1;
  endtask
  always @(negedge i_core_clk) begin
    frr_note_t n;
    if (q.size() > 0 && q[0].due == cyc) begin
      n = q.pop_front();
      num_checks++;
      if ({mrd, frd, rep, al_n, wn_n, sd} !== {n.rm, n.rf, n.rep, n.al, n.wn, n.sd})
        bad("pins or registers differ");
      if (n.gc) begin
        num_checks++;
        if ({gl, gh, gz} !== n.g) bad("gate action differs");
      end
    end
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad("run too long");
    conclude();
  end
  initial begin
    logic [15:0] rm, rf;
    int idx;
    void'($urandom(32'hE7DCBE0D));
    do_reset();
    for (int b = 0; b < 18; b++) begin
      for (int p = 0; p < 2; p++) begin
        idx = (b == 16) ? 10 : (b == 17) ? 9 : b;
        rm = 16'($urandom);
        rf = 16'($urandom);
        rm[idx] = p[0];
        rf[15] = p[0];
        step(rm, rf, 18'h1 << b, 1'h1);
      end
    end
    for (int c = 0; c < 4; c++) begin
      step({3'h0, 2'(c), 11'h0}, FRR_FS_RESET, 18'h1 << 11, 1'h1);
      step({3'h0, 2'(c), 11'h0}, FRR_FS_RESET, 18'h1 << 12, 1'b1);
      step(16'h0, {6'h0, 2'(c), 8'h0}, 18'h1 << 13, 1'b1);
      step(16'h0800, {12'h0, 2'(c), 2'h0}, 18'h1 << 11, 1'b1);
      step(16'h0, {4'h0, 1'(c), 11'h0}, 18'h1 << 3, 1'h1);
    end
    repeat (40) step(16'($urandom), 16'($urandom), 18'($urandom), 1'h1);
    f = 18'h3FFFF;
    do_reset();
    step(16'h0, 16'h0, 18'h0, 1'b1);
    repeat (3) @(posedge i_core_clk);
    if (q.size() != 0) bad("results never arrived");
    conclude();
  end
endmodule
